// ---- io_test_mode_forcing_tb_top.sv ----
// Self-checking bench for the contact I/O test-mode forcing block
module io_test_mode_forcing_tb_top;
  import itf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, nrst = 0, psel = 0, pen = 0, pwr = 0, trig = 0;
  logic [7:0] paddr = '0, ctrl = '0, lvl = '0, frz = '0;
  logic [31:0] pwdata = '0;
  logic [15:0] isel = 16'hE4E4;
  logic [15:0] osel = 16'hE4E4;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, act, led;
  wire logic [7:0] cin, rep, drv;
  int errors = 0;
  int tests_run = 0;
  logic [33:0] expq[$];

  always #5 clk = ~clk;

  itf_top #(.N_IN(8), .N_OUT(8), .FLASH_HALF_CYC(4)) i_dut (.i_ref_clk(clk), .i_nrst(nrst),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_trig_operand(trig),
    .i_contact_in(cin), .i_out_ctrl(ctrl), .o_in_report(rep), .o_out_drive(drv),
    .o_test_active(act), .o_test_led(led));
  itf_field_model i_field (.i_level(lvl), .o_contact(cin));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] er, input logic ee);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    pen <= 1'b0;
    @(posedge clk);
    pen <= 1'b1;
    expq.push_back({~w, ee, er});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      summarize();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // Oldest expected answer is matched against each completed access
  always @(posedge clk) begin
    logic [33:0] e;
    if (psel && pen && pready === 1'b1) begin
      e = expq.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("prdata", e[31:0], prdata);
    end
  end

  function automatic logic [7:0] exp_in(input logic a, input logic [7:0] c);
    for (int k = 0; k < 8; k++) begin
      exp_in[k] = (a && isel[2*k+:2] == IN_SEL_OPEN) ? 1'b0 :
                  (a && isel[2*k+:2] == IN_SEL_CLOSED) ? 1'b1 : c[k];
    end
  endfunction

  function automatic logic [7:0] exp_out(input logic a, input logic [7:0] c);
    for (int k = 0; k < 8; k++) begin
      case (a ? osel[2*k+:2] : OUT_SEL_DIS)
        OUT_SEL_ENERGIZE: exp_out[k] = 1'b1;
        OUT_SEL_DEENERGIZE: exp_out[k] = 1'b0;
        OUT_SEL_FREEZE: exp_out[k] = frz[k];
        default: exp_out[k] = c[k];
      endcase
    end
  endfunction

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_io(input logic a);
    chk("drive", {24'h0, exp_out(a, ctrl)}, {24'h0, drv});
    chk("report", {24'h0, exp_in(a, lvl)}, {24'h0, rep});
  endtask

  task automatic shuffle(input logic a);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      ctrl <= 8'($urandom);
      lvl <= 8'($urandom);
      wt(5);
      chk_io(a);
    end
  endtask

  initial begin
    #200000;
    errors++;
    summarize();
  end

  initial begin
    void'($urandom(56));
    repeat (6) @(posedge clk);
    chk("active in reset", 0, {31'h0, act});
    nrst <= 1'b1;
    apb(0, OFS_CTRL, 0, 0, 0);
    apb(0, OFS_STATUS, 0, 0, 0);
    apb(1, 8'h18, 32'h5, 0, 1);
    apb(0, 8'h18, 0, 0, 1);
    shuffle(0);
    apb(1, OFS_IN_FORCE, {16'h0, isel}, 0, 0);
    apb(1, OFS_OUT_FORCE, {16'h0, osel}, 0, 0);
    apb(0, OFS_IN_FORCE, 0, {16'h0, isel}, 0);
    apb(1, OFS_CTRL, 32'h3, 0, 0);
    wt(3);
    chk("idle active", 0, {31'h0, act});
    chk_io(0);
    frz = ctrl;
    @(posedge clk);
    trig <= 1'b1;
    wt(1);
    chk("entry active", 1, {31'h0, act});
    chk("entry led", 1, {31'h0, led});
    chk_io(1);
    wt(2);
    chk("led held", 1, {31'h0, led});
    wt(4);
    chk("led flash", 0, {31'h0, led});
    shuffle(1);
    @(posedge clk);
    trig <= 1'b0;
    wt(1);
    chk("exit active", 0, {31'h0, act});
    chk("exit led", 0, {31'h0, led});
    chk_io(0);
    apb(1, OFS_CTRL, 32'h0, 0, 0);
    frz = ctrl;
    apb(1, OFS_CTRL, 32'h1, 0, 0);
    wt(2);
    chk("const entry", 1, {31'h0, act});
    chk_io(1);
    apb(0, OFS_OUT_STATE, 0, {24'h0, exp_out(1, ctrl)}, 0);
    apb(0, OFS_IN_STATE, 0, {24'h0, exp_in(1, lvl)}, 0);
    apb(0, OFS_OUT_FORCE, 0, {16'h0, osel}, 0);
    isel = 16'h0;
    apb(1, OFS_IN_FORCE, 0, 0, 0);
    wt(4);
    chk("revert", {24'h0, lvl}, {24'h0, rep});
    apb(1, OFS_CTRL, 32'h0, 0, 0);
    wt(2);
    chk("disable", 0, {31'h0, act});
    apb(1, OFS_CTRL, 32'h1, 0, 0);
    wt(2);
    chk("rearm", 1, {31'h0, act});
    @(posedge clk);
    nrst <= 1'b0;
    wt(1);
    chk("reset active", 0, {31'h0, act});
    chk("reset drive", 0, {24'h0, drv});
    chk("reset report", 0, {24'h0, rep});
    @(posedge clk);
    nrst <= 1'b1;
    wt(2);
    chk("after reset", 0, {31'h0, act});
    apb(0, OFS_CTRL, 0, 0, 0);
    apb(0, OFS_OUT_FORCE, 0, 0, 0);
    chk_io(0);
    summarize();
  end
endmodule // io_test_mode_forcing_tb_top

// ---- itf_field_model.sv ----
// Field wiring model that presents contact levels to the relay terminals
module itf_field_model (
  input wire logic [7:0] i_level,
  output logic [7:0] o_contact
);
  timeunit 1ns;
  timeprecision 1ps;
  // Field contacts are asynchronous to the relay clock, so they land off the edge
  assign #3 o_contact = i_level;
endmodule // itf_field_model

// ---- itf_pkg.sv ----
// Constants shared by the contact I/O test-mode forcing block
package itf_pkg;
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_IN_FORCE = 8'h04;
  localparam logic [APB_AW-1:0] OFS_OUT_FORCE = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_IN_STATE = 8'h10;
  localparam logic [APB_AW-1:0] OFS_OUT_STATE = 8'h14;
  // Control register fields
  localparam int CTRL_FN_EN_BIT = 0;
  localparam int CTRL_TRIG_SEL_BIT = 1;
  localparam logic CTRL_FN_EN_RST = 1'h0;
  localparam logic CTRL_TRIG_SEL_RST = 1'h0;
  localparam logic TRIG_SEL_CONST = 1'h0;
  localparam logic TRIG_SEL_OPERAND = 1'h1;
  // Status register fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_LED_BIT = 1;
  // Per-channel force selections, two bits each
  localparam int SEL_W = 2;
  localparam logic [SEL_W-1:0] IN_SEL_DIS = 2'h0;
  localparam logic [SEL_W-1:0] IN_SEL_OPEN = 2'h1;
  localparam logic [SEL_W-1:0] IN_SEL_CLOSED = 2'h2;
  localparam logic [SEL_W-1:0] OUT_SEL_DIS = 2'h0;
  localparam logic [SEL_W-1:0] OUT_SEL_ENERGIZE = 2'h1;
  localparam logic [SEL_W-1:0] OUT_SEL_DEENERGIZE = 2'h2;
  localparam logic [SEL_W-1:0] OUT_SEL_FREEZE = 2'h3;
  localparam int N_IN_DEF = 8;
  localparam int N_OUT_DEF = 8;
  // Indicator flash timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FLASH_HALF_NS = 250000000;
  localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;
endpackage

// ---- itf_top.sv ----
// Contact input/output test-mode forcing with an APB register slave
// What this block does
// - Test mode needs function enabled and trigger 1
// - Constant trigger: starts when function becomes enabled
// - Operand trigger: starts when operand becomes 1
// - Indicator flashes while test mode is active
// - Internal logic and operands pass untouched
// - Independent force selection per input and output
// - Disabled input reports its sensed terminal state
// - Open input reports 0 during test mode
// - Closed input reports 1 during test mode
// - Each input reverts when its own selection is disabled
// - Disabled output follows its control operand
// - Energize output is closed during test mode
// - De-energize output is open during test mode
// - Freeze output holds its state from entry
// - On reads as 1, off as 0
module itf_top #(
  parameter int N_IN = itf_pkg::N_IN_DEF,
  parameter int N_OUT = itf_pkg::N_OUT_DEF,
  parameter int FLASH_HALF_CYC = itf_pkg::FLASH_HALF_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [itf_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_trig_operand,
  input wire logic [N_IN-1:0] i_contact_in,
  input wire logic [N_OUT-1:0] i_out_ctrl,
  output logic [N_IN-1:0] o_in_report,
  output logic [N_OUT-1:0] o_out_drive,
  output logic o_test_active,
  output logic o_test_led
);
  import itf_pkg::*;

  function automatic logic [SEL_W-1:0] sel_at(input logic [31:0] vec, input int idx);
    sel_at = vec[idx*SEL_W +: SEL_W];
  endfunction

  // Configuration registers
  logic fn_en_r, fn_en_nxt, trig_sel_r, trig_sel_nxt;
  logic [SEL_W*N_IN-1:0] in_force_r, in_force_nxt;
  logic [SEL_W*N_OUT-1:0] out_force_r, out_force_nxt;
  // APB state
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic wr_take, addr_ok;
  // Pin synchronisers
  logic [N_IN-1:0] in_meta_r, in_sync_r;
  // Test mode and contact state
  logic test_r, test_nxt, trig_val;
  logic [N_IN-1:0] in_rep_r, in_rep_nxt;
  logic [N_OUT-1:0] out_r, out_nxt, frozen_r, frozen_nxt;
  logic led_r, led_nxt;
  logic [31:0] flash_cnt_r, flash_cnt_nxt;

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_in_report = in_rep_r;
  assign o_out_drive = out_r;
  assign o_test_active = test_r;
  assign o_test_led = led_r;

  // APB slave: one wait state, write lands on the edge that samples pready
  // Unmapped offsets keep the same timing and answer with an error flag
  always_comb begin
    addr_ok = (i_paddr == OFS_CTRL) || (i_paddr == OFS_IN_FORCE) ||
              (i_paddr == OFS_OUT_FORCE) || (i_paddr == OFS_STATUS) ||
              (i_paddr == OFS_IN_STATE) || (i_paddr == OFS_OUT_STATE);
    wr_take = i_psel && i_penable && i_pwrite && pready_r;
    pready_nxt = i_psel && i_penable && !pready_r;
    pslverr_nxt = pready_nxt && !addr_ok;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt && !i_pwrite) begin
      unique case (i_paddr)
        OFS_CTRL: begin
          prdata_nxt[CTRL_FN_EN_BIT] = fn_en_r;
          prdata_nxt[CTRL_TRIG_SEL_BIT] = trig_sel_r;
        end
        OFS_IN_FORCE: prdata_nxt[SEL_W*N_IN-1:0] = in_force_r;
        OFS_OUT_FORCE: prdata_nxt[SEL_W*N_OUT-1:0] = out_force_r;
        OFS_STATUS: begin
          prdata_nxt[STAT_ACTIVE_BIT] = test_r;
          prdata_nxt[STAT_LED_BIT] = led_r;
        end
        OFS_IN_STATE: prdata_nxt[N_IN-1:0] = in_rep_r;
        OFS_OUT_STATE: prdata_nxt[N_OUT-1:0] = out_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // Setting registers written by software
  always_comb begin
    fn_en_nxt = fn_en_r;
    trig_sel_nxt = trig_sel_r;
    in_force_nxt = in_force_r;
    out_force_nxt = out_force_r;
    if (wr_take) begin
      unique case (i_paddr)
        OFS_CTRL: begin
          fn_en_nxt = i_pwdata[CTRL_FN_EN_BIT];
          trig_sel_nxt = i_pwdata[CTRL_TRIG_SEL_BIT];
        end
        OFS_IN_FORCE: in_force_nxt = i_pwdata[SEL_W*N_IN-1:0];
        OFS_OUT_FORCE: out_force_nxt = i_pwdata[SEL_W*N_OUT-1:0];
        default: fn_en_nxt = fn_en_r;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fn_en_r <= CTRL_FN_EN_RST;
      trig_sel_r <= CTRL_TRIG_SEL_RST;
      in_force_r <= '0;
      out_force_r <= '0;
    end else begin
      fn_en_r <= fn_en_nxt;
      trig_sel_r <= trig_sel_nxt;
      in_force_r <= in_force_nxt;
      out_force_r <= out_force_nxt;
    end
  end

  // Field contacts are asynchronous to the clock
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_meta_r <= '0;
      in_sync_r <= '0;
    end else begin
      in_meta_r <= i_contact_in;
      in_sync_r <= in_meta_r;
    end
  end

  // Test mode entry and contact overrides. Everything keys off test_nxt so
  // entry and exit take effect on all channels at the same edge.
  always_comb begin
    // A constant trigger lets the enable setting alone start and stop test mode
    trig_val = (trig_sel_r == TRIG_SEL_CONST) ? 1'b1 : i_trig_operand;
    test_nxt = fn_en_r && trig_val;
    // Capture from the drive register, the state the contacts held before entry
    frozen_nxt = (test_nxt && !test_r) ? out_r : frozen_r;
    for (int i = 0; i < N_IN; i++) begin
      // Revert is per channel, so a disabled channel tracks its pin while others stay forced
      in_rep_nxt[i] = in_sync_r[i];
      if (test_nxt) begin
        unique case (sel_at(32'(in_force_r), i))
          IN_SEL_OPEN: in_rep_nxt[i] = 1'b0;
          IN_SEL_CLOSED: in_rep_nxt[i] = 1'b1;
          default: in_rep_nxt[i] = in_sync_r[i];
        endcase
      end
    end
    for (int j = 0; j < N_OUT; j++) begin
      out_nxt[j] = i_out_ctrl[j];
      if (test_nxt) begin
        unique case (sel_at(32'(out_force_r), j))
          OUT_SEL_ENERGIZE: out_nxt[j] = 1'b1;
          OUT_SEL_DEENERGIZE: out_nxt[j] = 1'b0;
          OUT_SEL_FREEZE: out_nxt[j] = test_r ? frozen_r[j] : out_r[j];
          default: out_nxt[j] = i_out_ctrl[j];
        endcase
      end
    end
  end

  // Only the contact paths are touched; the trigger operand and control
  // operands are never gated, so upstream logic runs as in service.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      test_r <= 1'b0;
      in_rep_r <= '0;
      out_r <= '0;
      frozen_r <= '0;
    end else begin
      test_r <= test_nxt;
      in_rep_r <= in_rep_nxt;
      out_r <= out_nxt;
      frozen_r <= frozen_nxt;
    end
  end

  // Indicator flash; lights at once on entry so a short test is still seen
  // The count restarts at every entry, so the first lit phase is a full half period
  always_comb begin
    flash_cnt_nxt = 32'h0000_0000;
    led_nxt = 1'b0;
    if (test_nxt && !test_r) begin
      led_nxt = 1'b1;
    end else if (test_nxt) begin
      if (flash_cnt_r >= 32'(FLASH_HALF_CYC - 1)) begin
        led_nxt = !led_r;
      end else begin
        flash_cnt_nxt = flash_cnt_r + 32'h0000_0001;
        led_nxt = led_r;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      flash_cnt_r <= 32'h0000_0000;
      led_r <= 1'b0;
    end else begin
      flash_cnt_r <= flash_cnt_nxt;
      led_r <= led_nxt;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  test_cause_a: assert property (##1 test_r == $past(fn_en_r && trig_val))
    else $error("test mode does not match enable and trigger");
  enable_edge_a: assert property (
    (trig_sel_nxt == TRIG_SEL_CONST && fn_en_nxt && !fn_en_r) |=> ##1 test_r)
    else $error("constant trigger did not start test on enable");
  operand_start_a: assert property (
    (trig_sel_r == TRIG_SEL_OPERAND && fn_en_r && i_trig_operand && !test_r) |=>
      test_r && led_r)
    else $error("operand did not start test mode");
  trig_gate_a: assert property (!fn_en_r |=> !test_r)
    else $error("test mode active while function disabled");
  led_dark_a: assert property (!test_r |-> !led_r)
    else $error("indicator lit outside test mode");
  led_entry_a: assert property ((test_nxt && !test_r) |=> led_r)
    else $error("indicator not lit at entry");
  flash_bound_a: assert property (flash_cnt_r < 32'(FLASH_HALF_CYC))
    else $error("flash counter ran past its half period");
  led_toggle_a: assert property (
    (test_nxt && test_r && flash_cnt_r == 32'(FLASH_HALF_CYC - 1)) |=> led_r != $past(led_r))
    else $error("indicator did not toggle at half period");
  exit_release_a: assert property (
    (test_r && !test_nxt) |=> (out_r == $past(i_out_ctrl)) && (in_rep_r == $past(in_sync_r)))
    else $error("overrides not released at exit");

  // Register bus answer timing, error flag and write landing
  apb_wait_a: assert property ((i_psel && i_penable && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("apb answer not one wait state");
  ready_pulse_a: assert property (pready_r |=> !pready_r)
    else $error("apb ready stood longer than one cycle");
  slverr_map_a: assert property ((i_psel && i_penable && !pready_r && !addr_ok) |=> pslverr_r)
    else $error("unmapped address not flagged");
  rdata_idle_a: assert property (!pready_r |-> prdata_r == 32'h0000_0000)
    else $error("read data not zero outside the answer");
  ctrl_land_a: assert property (
    (wr_take && i_paddr == OFS_CTRL) |=> fn_en_r == $past(i_pwdata[CTRL_FN_EN_BIT]) &&
      trig_sel_r == $past(i_pwdata[CTRL_TRIG_SEL_BIT]))
    else $error("control write did not land");
  in_force_land_a: assert property (
    (wr_take && i_paddr == OFS_IN_FORCE) |=> in_force_r == $past(i_pwdata[SEL_W*N_IN-1:0]))
    else $error("input force write did not land");
  out_force_land_a: assert property (
    (wr_take && i_paddr == OFS_OUT_FORCE) |=> out_force_r == $past(i_pwdata[SEL_W*N_OUT-1:0]))
    else $error("output force write did not land");
  bad_write_a: assert property (
    (wr_take && !addr_ok) |=> $stable(fn_en_r) && $stable(in_force_r) && $stable(out_force_r))
    else $error("write to unmapped address changed a setting");

  // Read data carries the live state of the register read
  status_read_a: assert property (
    (pready_nxt && !i_pwrite && i_paddr == OFS_STATUS) |=>
      prdata_r[STAT_ACTIVE_BIT] == $past(test_r))
    else $error("status read does not show test mode");
  in_state_read_a: assert property (
    (pready_nxt && !i_pwrite && i_paddr == OFS_IN_STATE) |=>
      prdata_r[N_IN-1:0] == $past(in_rep_r))
    else $error("input state read does not match reports");
  out_state_read_a: assert property (
    (pready_nxt && !i_pwrite && i_paddr == OFS_OUT_STATE) |=>
      prdata_r[N_OUT-1:0] == $past(out_r))
    else $error("output state read does not match drive");

  // One checker set per contact input
  for (genvar g = 0; g < N_IN; g++) begin : g_in_chk
    in_pass_a: assert property (
      (!test_nxt || sel_at(32'(in_force_r), g) == IN_SEL_DIS) |=>
        in_rep_r[g] == $past(in_sync_r[g]))
      else $error("unforced input not reporting sensed state");
    in_spare_a: assert property (
      (test_nxt && sel_at(32'(in_force_r), g) != IN_SEL_OPEN &&
        sel_at(32'(in_force_r), g) != IN_SEL_CLOSED) |=> in_rep_r[g] == $past(in_sync_r[g]))
      else $error("unforced input not reporting sensed state in test mode");
    in_open_a: assert property (
      (test_nxt && sel_at(32'(in_force_r), g) == IN_SEL_OPEN) |=> !in_rep_r[g])
      else $error("open input not reporting 0");
    in_closed_a: assert property (
      (test_nxt && sel_at(32'(in_force_r), g) == IN_SEL_CLOSED) |=> in_rep_r[g])
      else $error("closed input not reporting 1");
  end

  // One checker set per contact output
  for (genvar h = 0; h < N_OUT; h++) begin : g_out_chk
    // The edge that releases reset still resets the flops, so it is skipped
    out_follow_a: assert property (
      $past(i_nrst) && (!test_nxt || sel_at(32'(out_force_r), h) == OUT_SEL_DIS) |=>
        out_r[h] == $past(i_out_ctrl[h]))
      else $error("unforced output not following operand");
    out_energize_a: assert property (
      (test_nxt && sel_at(32'(out_force_r), h) == OUT_SEL_ENERGIZE) |=> out_r[h])
      else $error("energized output not closed");
    out_deenergize_a: assert property (
      (test_nxt && sel_at(32'(out_force_r), h) == OUT_SEL_DEENERGIZE) |=> !out_r[h])
      else $error("de-energized output not open");
    out_freeze_a: assert property (
      (test_nxt && test_r && sel_at(32'(out_force_r), h) == OUT_SEL_FREEZE) |=>
        $stable(out_r[h]) && out_r[h] == $past(frozen_r[h]))
      else $error("frozen output changed");
    freeze_grab_a: assert property (
      (test_nxt && !test_r && sel_at(32'(out_force_r), h) == OUT_SEL_FREEZE) |=>
        out_r[h] == $past(out_r[h]) && frozen_r[h] == $past(out_r[h]))
      else $error("frozen output did not keep its pre-test state");
  end

  test_entry_c: cover property (!test_r ##1 test_r);
  test_exit_c: cover property (test_r ##1 !test_r);
  led_toggle_c: cover property (test_r && led_r ##1 test_r && !led_r);
  apb_write_c: cover property (wr_take && i_paddr == OFS_OUT_FORCE);
  apb_error_c: cover property (pready_r && pslverr_r);
endmodule // itf_top
